/* hdl/act_regs.svh */
// Contract
// - core B timing trim applies: single mode, calibration on, second input
// - core A offset: dual mode, first input, calibration on
// - core A offset: dual mode, second input, calibration on
// - core A offset: single mode, first input, calibration on
// - core A offset: single mode, second input with 90 degree phase, calibration on
// - core B offset register used when core B samples first input, calibration on
// - defaults load from fuses; printed reset 0x0; offset bits 15:12 reserved
// - software reads back and overwrites trimmed values
`ifndef ACT_REGS_SVH
`define ACT_REGS_SVH
`define ACT_IDX_CTRL         12'h0300
`define ACT_IDX_STAT         12'h0301
`define ACT_IDX_TIM_B_INB    12'h031B
`define ACT_IDX_OFF_A_INA_D  12'h0344
`define ACT_IDX_OFF_A_INB_D  12'h0346
`define ACT_IDX_OFF_A_INA_S  12'h0348
`define ACT_IDX_OFF_A_INB_90 12'h034A
`define ACT_IDX_OFF_B_INA    12'h034C
`define ACT_CTRL_SINGLE      0
`define ACT_CTRL_PH90        1
`define ACT_CTRL_CAL         2
`define ACT_CTRL_A_INB       3
`define ACT_CTRL_B_INB       4
`define ACT_CTRL_W           5
`define ACT_CTRL_RST         5'h00
`define ACT_TRIM_RST         16'h0000
`define ACT_TIM_RST          8'h00
`define ACT_OFF_MSB          11
`define ACT_RESP_OKAY        2'h0
`define ACT_RESP_SLVERR      2'h2
`endif

/* hdl/act_pkg.sv */
`default_nettype none
package act_pkg;
   typedef enum logic [2:0] {
      ACT_OFF_A_INA_D,
      ACT_OFF_A_INB_D,
      ACT_OFF_A_INA_S,
      ACT_OFF_A_INB_90,
      ACT_OFF_B_INA,
      ACT_OFF_NONE
   } act_osel_t;
   typedef struct packed {
      logic [7:0]  tim_b_inb;
      logic [15:0] off_a_ina_d;
      logic [15:0] off_a_inb_d;
      logic [15:0] off_a_ina_s;
      logic [15:0] off_a_inb_90;
      logic [15:0] off_b_ina;
   } act_fuse_t;
   typedef struct packed {
      logic        tim_b_vld;
      logic [7:0]  tim_b;
      logic        off_a_vld;
      logic [11:0] off_a;
      logic        off_b_vld;
      logic [11:0] off_b;
   } act_trim_t;
endpackage : act_pkg
`default_nettype wire

/* hdl/act_trim_bank.sv */
// The AXI4-Lite slave port is this design's own decision.
`include "act_regs.svh"
`default_nettype none
module act_trim_bank #(
   parameter int ADDR_W = 14
) (
   input  wire logic              clk_sys,
   input  wire logic              sys_rst,
   input  wire logic [ADDR_W-1:0] s_awaddr,
   input  wire logic              s_awvalid,
   output logic                   s_awready,
   input  wire logic [31:0]       s_wdata,
   input  wire logic [3:0]        s_wstrb,
   input  wire logic              s_wvalid,
   output logic                   s_wready,
   output logic [1:0]             s_bresp,
   output logic                   s_bvalid,
   input  wire logic              s_bready,
   input  wire logic [ADDR_W-1:0] s_araddr,
   input  wire logic              s_arvalid,
   output logic                   s_arready,
   output logic [31:0]            s_rdata,
   output logic [1:0]             s_rresp,
   output logic                   s_rvalid,
   input  wire logic              s_rready,
   input  wire act_pkg::act_fuse_t fuse_val,
   output act_pkg::act_trim_t     trim_out
);
   localparam int NOFF = 5;

   logic [ADDR_W-1:0]       awaddr_q, awaddr_d;
   logic [31:0]             wdata_q, wdata_d;
   logic [3:0]              wstrb_q, wstrb_d;
   logic                    awhold_q, awhold_d;
   logic                    whold_q, whold_d;
   logic                    awready_q, awready_d;
   logic                    wready_q, wready_d;
   logic                    bvalid_q, bvalid_d;
   logic [1:0]              bresp_q, bresp_d;
   logic                    arready_q, arready_d;
   logic                    rvalid_q, rvalid_d;
   logic [31:0]             rdata_q, rdata_d;
   logic [1:0]              rresp_q, rresp_d;
   logic [`ACT_CTRL_W-1:0]  ctrl_q, ctrl_d;
   logic [7:0]              tim_q, tim_d;
   logic [15:0]             off_q [NOFF];
   logic [15:0]             off_d [NOFF];
   logic                    load_q, load_d;
   act_pkg::act_trim_t      trim_q, trim_d;
   act_pkg::act_osel_t      sel_a, sel_b;
   logic                    aw_take, w_take, ar_take;
   logic [11:0]             widx, ridx;
   logic                    cal, single, ph90, a_inb, b_inb;

   // address index of a word access
   assign widx = aw_take ? 12'(s_awaddr[ADDR_W-1:2]) : 12'(awaddr_q[ADDR_W-1:2]);
   assign ridx = 12'(s_araddr[ADDR_W-1:2]);
   assign aw_take = s_awvalid && awready_q;
   assign w_take  = s_wvalid && wready_q;
   assign ar_take = s_arvalid && arready_q;

   assign cal    = ctrl_q[`ACT_CTRL_CAL];
   assign single = ctrl_q[`ACT_CTRL_SINGLE];
   assign ph90   = ctrl_q[`ACT_CTRL_PH90];
   assign a_inb  = ctrl_q[`ACT_CTRL_A_INB];
   assign b_inb  = ctrl_q[`ACT_CTRL_B_INB];

   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] data,
                                           input logic [3:0]  strb);
      logic [15:0] res;
      res = old;
      if (strb[0]) begin
         res[7:0] = data[7:0];
      end
      if (strb[1]) begin
         res[15:8] = data[15:8];
      end
      return res;
   endfunction : merge16

   // write channel and register updates
   always_comb begin
      awaddr_d  = awaddr_q;
      wdata_d   = wdata_q;
      wstrb_d   = wstrb_q;
      awhold_d  = awhold_q;
      whold_d   = whold_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      ctrl_d    = ctrl_q;
      tim_d     = tim_q;
      off_d     = off_q;
      load_d    = 1'b0;
      if (s_bready && bvalid_q) begin
         bvalid_d = 1'b0;
      end
      if (aw_take) begin
         awaddr_d = s_awaddr;
         awhold_d = 1'b1;
      end
      if (w_take) begin
         wdata_d = s_wdata;
         wstrb_d = s_wstrb;
         whold_d = 1'b1;
      end
      if (load_q) begin
         tim_d    = fuse_val.tim_b_inb;
         off_d[0] = fuse_val.off_a_ina_d;
         off_d[1] = fuse_val.off_a_inb_d;
         off_d[2] = fuse_val.off_a_ina_s;
         off_d[3] = fuse_val.off_a_inb_90;
         off_d[4] = fuse_val.off_b_ina;
      end else if (awhold_d && whold_d && !bvalid_q) begin
         awhold_d = 1'b0;
         whold_d  = 1'b0;
         bvalid_d = 1'b1;
         bresp_d  = `ACT_RESP_OKAY;
         if (widx == `ACT_IDX_CTRL) begin
            if (wstrb_d[0]) begin
               ctrl_d = wdata_d[`ACT_CTRL_W-1:0];
            end
         end else if (widx == `ACT_IDX_STAT) begin
            bresp_d = `ACT_RESP_OKAY;
         end else if (widx == `ACT_IDX_TIM_B_INB) begin
            if (wstrb_d[0]) begin
               tim_d = wdata_d[7:0];
            end
         end else if (widx == `ACT_IDX_OFF_A_INA_D) begin
            off_d[0] = merge16(off_q[0], wdata_d, wstrb_d);
         end else if (widx == `ACT_IDX_OFF_A_INB_D) begin
            off_d[1] = merge16(off_q[1], wdata_d, wstrb_d);
         end else if (widx == `ACT_IDX_OFF_A_INA_S) begin
            off_d[2] = merge16(off_q[2], wdata_d, wstrb_d);
         end else if (widx == `ACT_IDX_OFF_A_INB_90) begin
            off_d[3] = merge16(off_q[3], wdata_d, wstrb_d);
         end else if (widx == `ACT_IDX_OFF_B_INA) begin
            off_d[4] = merge16(off_q[4], wdata_d, wstrb_d);
         end else begin
            bresp_d = `ACT_RESP_SLVERR;
         end
      end
      awready_d = !awhold_d && !bvalid_d && !load_q;
      wready_d  = !whold_d && !bvalid_d && !load_q;
   end

   // read channel
   always_comb begin
      rvalid_d = rvalid_q;
      rdata_d  = rdata_q;
      rresp_d  = rresp_q;
      if (s_rready && rvalid_q) begin
         rvalid_d = 1'b0;
      end
      if (ar_take) begin
         rvalid_d = 1'b1;
         rresp_d  = `ACT_RESP_OKAY;
         rdata_d  = 32'h0000_0000;
         if (ridx == `ACT_IDX_CTRL) begin
            rdata_d = 32'(ctrl_q);
         end else if (ridx == `ACT_IDX_STAT) begin
            rdata_d = 32'({trim_q.off_b_vld, trim_q.off_a_vld, trim_q.tim_b_vld});
         end else if (ridx == `ACT_IDX_TIM_B_INB) begin
            rdata_d = 32'(tim_q);
         end else if (ridx == `ACT_IDX_OFF_A_INA_D) begin
            rdata_d = 32'(off_q[0]);
         end else if (ridx == `ACT_IDX_OFF_A_INB_D) begin
            rdata_d = 32'(off_q[1]);
         end else if (ridx == `ACT_IDX_OFF_A_INA_S) begin
            rdata_d = 32'(off_q[2]);
         end else if (ridx == `ACT_IDX_OFF_A_INB_90) begin
            rdata_d = 32'(off_q[3]);
         end else if (ridx == `ACT_IDX_OFF_B_INA) begin
            rdata_d = 32'(off_q[4]);
         end else begin
            rresp_d = `ACT_RESP_SLVERR;
         end
      end
      arready_d = !rvalid_d;
   end

   // trim selection per core
   always_comb begin
      sel_a = act_pkg::ACT_OFF_NONE;
      sel_b = act_pkg::ACT_OFF_NONE;
      if (cal) begin
         if (!single && !a_inb) begin
            sel_a = act_pkg::ACT_OFF_A_INA_D;
         end else if (!single && a_inb) begin
            sel_a = act_pkg::ACT_OFF_A_INB_D;
         end else if (!a_inb) begin
            sel_a = act_pkg::ACT_OFF_A_INA_S;
         end else if (ph90) begin
            sel_a = act_pkg::ACT_OFF_A_INB_90;
         end
         if (!b_inb) begin
            sel_b = act_pkg::ACT_OFF_B_INA;
         end
      end
      trim_d = '0;
      trim_d.tim_b_vld = cal && single && b_inb;
      trim_d.tim_b     = trim_d.tim_b_vld ? tim_q : `ACT_TIM_RST;
      trim_d.off_a_vld = (sel_a != act_pkg::ACT_OFF_NONE);
      if (trim_d.off_a_vld) begin
         trim_d.off_a = off_q[int'(sel_a)][`ACT_OFF_MSB:0];
      end
      trim_d.off_b_vld = (sel_b != act_pkg::ACT_OFF_NONE);
      if (trim_d.off_b_vld) begin
         trim_d.off_b = off_q[int'(sel_b)][`ACT_OFF_MSB:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         awaddr_q  <= '0;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
         awhold_q  <= 1'b0;
         whold_q   <= 1'b0;
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `ACT_RESP_OKAY;
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= `ACT_RESP_OKAY;
         ctrl_q    <= `ACT_CTRL_RST;
         tim_q     <= `ACT_TIM_RST;
         for (int i = 0; i < NOFF; i++) begin
            off_q[i] <= `ACT_TRIM_RST;
         end
         load_q    <= 1'b1;
         trim_q    <= '0;
      end else begin
         awaddr_q  <= awaddr_d;
         wdata_q   <= wdata_d;
         wstrb_q   <= wstrb_d;
         awhold_q  <= awhold_d;
         whold_q   <= whold_d;
         awready_q <= awready_d;
         wready_q  <= wready_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         arready_q <= arready_d;
         rvalid_q  <= rvalid_d;
         rdata_q   <= rdata_d;
         rresp_q   <= rresp_d;
         ctrl_q    <= ctrl_d;
         tim_q     <= tim_d;
         off_q     <= off_d;
         load_q    <= load_d;
         trim_q    <= trim_d;
      end
   end

   assign s_awready = awready_q;
   assign s_wready  = wready_q;
   assign s_bvalid  = bvalid_q;
   assign s_bresp   = bresp_q;
   assign s_arready = arready_q;
   assign s_rvalid  = rvalid_q;
   assign s_rdata   = rdata_q;
   assign s_rresp   = rresp_q;
   assign trim_out  = trim_q;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   sequence s_cal_single_inb;
      cal && single && b_inb;
   endsequence

   AST_TIM_B_APPLY: assert property (
      s_cal_single_inb |=> trim_q.tim_b_vld && trim_q.tim_b == $past(tim_q))
      else $error("core B timing trim not applied");
   AST_OFF_A_DUAL_A: assert property (
      cal && !single && !a_inb |=> trim_q.off_a_vld && trim_q.off_a == $past(off_q[0][11:0]))
      else $error("dual first input offset wrong");
   AST_OFF_A_DUAL_B: assert property (
      cal && !single && a_inb |=> trim_q.off_a == $past(off_q[1][11:0]))
      else $error("dual second input offset wrong");
   AST_OFF_A_SNG_A: assert property (
      cal && single && !a_inb |=> trim_q.off_a == $past(off_q[2][11:0]))
      else $error("single first input offset wrong");
   AST_OFF_A_PH90: assert property (
      cal && single && a_inb && ph90 |=> trim_q.off_a_vld && trim_q.off_a == $past(off_q[3][11:0]))
      else $error("90 degree offset wrong");
   AST_OFF_B_INA: assert property (
      cal && !b_inb |=> trim_q.off_b_vld && trim_q.off_b == $past(off_q[4][11:0]))
      else $error("core B offset wrong");
   AST_FUSE_LOAD: assert property (
      load_q && !sys_rst |=> tim_q == $past(fuse_val.tim_b_inb)
                             && off_q[4] == $past(fuse_val.off_b_ina))
      else $error("fuse defaults not loaded");
   AST_READBACK: assert property (
      ar_take && ridx == `ACT_IDX_TIM_B_INB |=> s_rvalid && s_rdata == 32'($past(tim_q)))
      else $error("timing trim readback wrong");
   AST_NO_CAL: assert property (
      !cal |=> !trim_q.tim_b_vld && !trim_q.off_a_vld && !trim_q.off_b_vld)
      else $error("trim applied without calibration");
endmodule : act_trim_bank
`default_nettype wire

/* verif/adc_core_trim_register_bank_test.sv */
`include "act_regs.svh"
`default_nettype none
module adc_core_trim_register_bank_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic                clk_sys;
   logic                sys_rst;
   logic [13:0]         s_awaddr, s_araddr;
   logic [31:0]         s_wdata, s_rdata;
   logic [3:0]          s_wstrb;
   logic [1:0]          s_bresp, s_rresp;
   logic                s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
   logic                s_arvalid, s_arready, s_rvalid, s_rready;
   act_pkg::act_fuse_t  fuse_val;
   act_pkg::act_trim_t  trim_out;
   int                  error_cnt, comparisons, cyc;
   logic [15:0]         sh [0:5];
   logic [11:0]         idx_tab [0:5];

   act_trim_bank #(.ADDR_W(14)) dut (
      .clk_sys, .sys_rst, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
      .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
      .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .fuse_val, .trim_out
   );

   always #20 clk_sys = ~clk_sys;

   // watchdog against a hung handshake
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         $display("[ERR] %0t timeout", $time);
         complete_run();
      end
   end

   task automatic complete_run;
      if (error_cnt == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t word got %h exp %h", $time, got, exp);
      end
   endtask : chk32

   task automatic chk_trim(input act_pkg::act_trim_t got, input act_pkg::act_trim_t exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t trim got %h exp %h", $time, got, exp);
      end
   endtask : chk_trim

   task automatic wr_chk(input logic [11:0] idx, input logic [31:0] d, input logic [1:0] er);
      s_awaddr  <= {idx, 2'b00};
      s_wdata   <= d;
      s_awvalid <= 1'b1;
      s_wvalid  <= 1'b1;
      s_bready  <= 1'b1;
      forever begin
         @(posedge clk_sys);
         if (s_awvalid && s_awready) s_awvalid <= 1'b0;
         if (s_wvalid && s_wready) s_wvalid <= 1'b0;
         if (s_bvalid) begin
            chk32({30'h0000_0000, s_bresp}, {30'h0000_0000, er});
            s_bready <= 1'b0;
            break;
         end
      end
      @(posedge clk_sys);
   endtask : wr_chk

   task automatic rd_chk(input logic [11:0] idx, input logic [31:0] ed, input logic [1:0] er);
      s_araddr  <= {idx, 2'b00};
      s_arvalid <= 1'b1;
      s_rready  <= 1'b1;
      forever begin
         @(posedge clk_sys);
         if (s_arvalid && s_arready) s_arvalid <= 1'b0;
         if (s_rvalid) begin
            chk32(s_rdata, ed);
            chk32({30'h0000_0000, s_rresp}, {30'h0000_0000, er});
            s_rready <= 1'b0;
            break;
         end
      end
      @(posedge clk_sys);
   endtask : rd_chk

   function automatic act_pkg::act_trim_t exp_trim(input logic [4:0] c);
      act_pkg::act_trim_t t;
      t = '0;
      if (c[`ACT_CTRL_CAL]) begin
         t.tim_b_vld = c[`ACT_CTRL_SINGLE] & c[`ACT_CTRL_B_INB];
         t.tim_b     = t.tim_b_vld ? sh[0][7:0] : 8'h00;
         t.off_a_vld = !(c[`ACT_CTRL_SINGLE] && c[`ACT_CTRL_A_INB] && !c[`ACT_CTRL_PH90]);
         if (!c[`ACT_CTRL_SINGLE]) t.off_a = c[`ACT_CTRL_A_INB] ? sh[2][11:0] : sh[1][11:0];
         else if (!c[`ACT_CTRL_A_INB]) t.off_a = sh[3][11:0];
         else if (c[`ACT_CTRL_PH90]) t.off_a = sh[4][11:0];
         t.off_b_vld = !c[`ACT_CTRL_B_INB];
         t.off_b     = t.off_b_vld ? sh[5][11:0] : 12'h000;
      end
      return t;
   endfunction : exp_trim

   task automatic load_sh;
      sh[0] = {8'h00, fuse_val.tim_b_inb};
      sh[1] = fuse_val.off_a_ina_d;
      sh[2] = fuse_val.off_a_inb_d;
      sh[3] = fuse_val.off_a_ina_s;
      sh[4] = fuse_val.off_a_inb_90;
      sh[5] = fuse_val.off_b_ina;
   endtask : load_sh

   task automatic t_fuse;
      for (int i = 0; i < 6; i++) begin
         rd_chk(idx_tab[i], {16'h0000, sh[i]}, `ACT_RESP_OKAY);
      end
      chk_trim(trim_out, '0);
   endtask : t_fuse

   task automatic t_rw;
      logic [31:0] d;
      for (int i = 0; i < 6; i++) begin
         d = 32'hFFFF_F0A0 + 32'(i);
         wr_chk(idx_tab[i], d, `ACT_RESP_OKAY);
         sh[i] = (i == 0) ? {8'h00, d[7:0]} : d[15:0];
         rd_chk(idx_tab[i], {16'h0000, sh[i]}, `ACT_RESP_OKAY);
      end
      // upper byte lane only
      s_wstrb <= 4'h2;
      wr_chk(`ACT_IDX_OFF_B_INA, 32'h0000_5500, `ACT_RESP_OKAY);
      s_wstrb <= 4'hF;
      sh[5] = {8'h55, sh[5][7:0]};
      rd_chk(`ACT_IDX_OFF_B_INA, {16'h0000, sh[5]}, `ACT_RESP_OKAY);
   endtask : t_rw

   task automatic t_bad;
      wr_chk(12'h0FFF, 32'h1234_5678, `ACT_RESP_SLVERR);
      rd_chk(12'h0FFF, 32'h0000_0000, `ACT_RESP_SLVERR);
   endtask : t_bad

   task automatic t_modes;
      logic [4:0] cv;
      act_pkg::act_trim_t et;
      for (int c = 0; c < 32; c++) begin
         cv = 5'(c);
         if (!cv[`ACT_CTRL_SINGLE] && cv[`ACT_CTRL_PH90]) continue;
         wr_chk(`ACT_IDX_CTRL, {27'h000_0000, cv}, `ACT_RESP_OKAY);
         repeat (2) @(posedge clk_sys);
         et = exp_trim(cv);
         chk_trim(trim_out, et);
         rd_chk(`ACT_IDX_STAT, {29'h0000_0000, et.off_b_vld, et.off_a_vld, et.tim_b_vld},
                `ACT_RESP_OKAY);
      end
   endtask : t_modes

   task automatic do_reset;
      sys_rst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clk_sys);
   endtask : do_reset

   initial begin
      clk_sys   = 1'b0;
      sys_rst   = 1'b1;
      cyc       = 0;
      error_cnt = 0;
      comparisons = 0;
      s_awaddr  = 14'h0000;
      s_araddr  = 14'h0000;
      s_wdata   = 32'h0000_0000;
      s_wstrb   = 4'hF;
      {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
      fuse_val  = '{8'h5A, 16'h0123, 16'h0456, 16'h0789, 16'h0ABC, 16'h0DEF};
      idx_tab   = '{`ACT_IDX_TIM_B_INB, `ACT_IDX_OFF_A_INA_D, `ACT_IDX_OFF_A_INB_D,
                    `ACT_IDX_OFF_A_INA_S, `ACT_IDX_OFF_A_INB_90, `ACT_IDX_OFF_B_INA};
      do_reset();
      load_sh();
      t_fuse();
      t_rw();
      t_bad();
      t_modes();
      // new fuse values must reload on reset
      fuse_val  <= '{8'hC3, 16'h0321, 16'h0654, 16'h0987, 16'h0CBA, 16'h0FED};
      do_reset();
      load_sh();
      t_fuse();
      complete_run();
   end
endmodule : adc_core_trim_register_bank_test
`default_nettype wire
